// ==== logic/usb_endpoint_status_bdt.sv ====
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
// Summary of operation
// - transfer status bits 6..3 give the endpoint of the oldest completed transfer not yet cleared.
// - transfer status bit 2 is 1 for IN, 0 for OUT or SETUP.
// - transfer status bit 1 is 1 for odd bank, 0 for even bank.
// - sixteen endpoints, each with its own identical control register.
// - control bit 4 enables handshakes; clear means no handshakes.
// - with IN and OUT enabled, bit 3 set refuses SETUP, clear accepts it.
// - control bit 2 allows OUT transactions; clear refuses them.
// - control bit 1 allows IN transactions; clear refuses them.
// - engine sets stall bit 0 on issued stall; stays until firmware or reset clears.
// - stall bit matters only while the endpoint is enabled.
// - control bits 7..5 always read zero.
// - device address clears on bus reset or device reset.
// - each SOF loads the 11-bit frame into low and high read-only registers.
// - 1 KB dual-port ram shared by CPU and engine, mapped 400h to 7FFh.
// - 400h..4FFh holds the descriptor table, upper banks hold buffers.
// - descriptors 0..63 are four bytes: status, count, address low, address high.
// - table holds 32, 33 or 64 descriptors, 128 to 256 bytes.
// - descriptors are plain ram until the endpoint's IN bit is set; undefined after reset.
// - status byte has CPU and engine layouts chosen by ownership.
// - transfer status reads a four-entry fifo; clearing the flag advances it.
// - a request to an unstalled endpoint whose control bits allow its token is answered with NAK while the status fifo is full.
// - status bit 7 is the ownership semaphore between CPU and engine.
module usb_endpoint_status_bdt (
  input  wire logic                                  pclk,
  input  wire logic                                  presetn,
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [usb_ep_pkg::PADDR_W-1:0]        paddr,
  input  wire logic [31:0]                           pwdata,
  input  wire logic [3:0]                            pstrb,
  output logic      [31:0]                           prdata,
  output logic                                       pready,
  output logic                                       pslverr,
  input  wire logic                                  xfer_done,
  input  wire usb_ep_pkg::xfer_info_t                xfer_info,
  input  wire logic                                  token_valid,
  input  wire usb_ep_pkg::token_t                    token,
  output usb_ep_pkg::answer_t                        token_answer,
  output logic                                       token_handshake,
  output logic      [usb_ep_pkg::RAM_ADDR_W-1:0]     token_desc_addr,
  input  wire logic                                  stall_issued,
  input  wire logic [3:0]                            stall_ep,
  input  wire logic                                  sof_valid,
  input  wire logic [10:0]                           sof_frame,
  input  wire logic                                  bus_reset,
  input  wire logic                                  eng_ram_en,
  input  wire logic                                  eng_ram_we,
  input  wire logic [usb_ep_pkg::RAM_ADDR_W-1:0]     eng_ram_addr,
  input  wire logic [7:0]                            eng_ram_wdata,
  output logic      [7:0]                            eng_ram_rdata,
  output usb_ep_pkg::desc_view_t                     eng_desc_view,
  output logic      [6:0]                            device_address,
  output logic      [usb_ep_pkg::NUM_EP-1:0]         desc_live,
  output logic      [8:0]                            table_bytes,
  output logic                                       status_fifo_full,
  output logic                                       xfer_flag
);

  localparam int NEP = usb_ep_pkg::NUM_EP;
  localparam int FD  = usb_ep_pkg::FIFO_DEPTH;

  // bus decode
  logic        acc;
  logic        wr_now;
  logic        rd_wait_ff;
  logic        is_ram;
  logic        is_ep;
  logic        mapped;
  logic [3:0]  ep_sel;
  logic [9:0]  ram_idx;

  assign acc    = psel && penable;
  assign is_ram = (paddr >= usb_ep_pkg::RAM_WIN_BASE);
  assign is_ep  = (paddr >= usb_ep_pkg::OFS_EP_CTRL) && (paddr <= usb_ep_pkg::OFS_EP_CTRL_END);
  assign ep_sel = paddr[5:2];
  assign ram_idx = paddr[11:2];
  assign mapped = (paddr[1:0] == 2'h0) &&
                  (is_ram || is_ep ||
                   paddr == usb_ep_pkg::OFS_XFER_STATUS ||
                   paddr == usb_ep_pkg::OFS_XFER_FLAG ||
                   paddr == usb_ep_pkg::OFS_DEV_ADDR ||
                   paddr == usb_ep_pkg::OFS_FRAME_LOW ||
                   paddr == usb_ep_pkg::OFS_FRAME_HIGH ||
                   paddr == usb_ep_pkg::OFS_USB_CFG ||
                   paddr == usb_ep_pkg::OFS_TABLE_SIZE);

  // writes finish at once; reads take one wait state so that read data
  // (ram included) always comes from flip-flops
  assign pready  = pwrite ? 1'b1 : rd_wait_ff;
  assign pslverr = acc && pready && !mapped;
  assign wr_now  = acc && pwrite && mapped && pstrb[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_wait_ff <= 1'b0;
    end else begin
      rd_wait_ff <= acc && !pwrite && !rd_wait_ff;
    end
  end

  // status fifo
  usb_ep_pkg::xfer_info_t fifo_ff [FD];
  logic [1:0] rd_ptr_ff;
  logic [1:0] wr_ptr_ff;
  logic [2:0] count_ff;
  logic       push;
  logic       pop;
  logic       flag_clear;

  assign status_fifo_full = (count_ff == 3'(FD));
  assign xfer_flag        = (count_ff != 3'h0);
  assign flag_clear = wr_now && (paddr == usb_ep_pkg::OFS_XFER_FLAG) && pwdata[0];
  assign push = xfer_done && !status_fifo_full;
  // clearing the flag advances the fifo; a waiting entry re-raises it at once
  assign pop  = flag_clear && xfer_flag;

  always_ff @(posedge pclk) begin
    if (push) begin
      fifo_ff[wr_ptr_ff] <= xfer_info;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr_ff <= 2'h0;
      wr_ptr_ff <= 2'h0;
      count_ff  <= 3'h0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 2'h1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 2'h1;
      end
      // push and pop together keep the count; an event that arrives while the fifo is full is lost, even with a pop in that cycle
      count_ff <= count_ff + {2'h0, push} - {2'h0, pop};
    end
  end

  // endpoint control registers
  logic [4:0] ep_ctrl_ff [NEP];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NEP; i++) begin
        ep_ctrl_ff[i] <= usb_ep_pkg::EPC_RST;
      end
    end else begin
      for (int i = 0; i < NEP; i++) begin
        if (wr_now && is_ep && (ep_sel == 4'(i))) begin
          ep_ctrl_ff[i] <= pwdata[4:0];
        end
        // set by the engine wins over a firmware clear in the same cycle
        if (stall_issued && (stall_ep == 4'(i))) begin
          ep_ctrl_ff[i][usb_ep_pkg::EPC_STALL] <= 1'b1;
        end
      end
    end
  end

  for (genvar g = 0; g < NEP; g++) begin : g_live
    // descriptors become live only once input is enabled
    assign desc_live[g] = ep_ctrl_ff[g][usb_ep_pkg::EPC_IN];
  end

  // device address, frame number, buffering mode
  logic [6:0]  dev_addr_ff;
  logic [10:0] frame_ff;
  logic [1:0]  pp_mode_ff;
  logic        bus_reset_flag_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_addr_ff <= usb_ep_pkg::DEV_ADDR_RST;
    end else if (bus_reset) begin
      dev_addr_ff <= usb_ep_pkg::DEV_ADDR_RST;
    end else if (wr_now && paddr == usb_ep_pkg::OFS_DEV_ADDR) begin
      dev_addr_ff <= pwdata[6:0];
    end
  end
  assign device_address = dev_addr_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_reset_flag_ff <= 1'b0;
    end else if (bus_reset) begin
      bus_reset_flag_ff <= 1'b1;
    end else if (wr_now && paddr == usb_ep_pkg::OFS_XFER_FLAG && pwdata[1]) begin
      bus_reset_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_ff <= 11'h000;
    end else if (sof_valid) begin
      frame_ff <= sof_frame;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pp_mode_ff <= usb_ep_pkg::PP_MODE_RST;
    end else if (wr_now && paddr == usb_ep_pkg::OFS_USB_CFG) begin
      pp_mode_ff <= pwdata[1:0];
    end
  end

  // table length follows the buffering mode; mode 3 falls back to no ping-pong
  always_comb begin
    unique case (pp_mode_ff)
      usb_ep_pkg::PP_EP0_OUT: table_bytes = 9'h084;
      usb_ep_pkg::PP_ALL:     table_bytes = 9'(usb_ep_pkg::TABLE_MAX_BYTES);
      default:                table_bytes = 9'h080;
    endcase
  end

  // descriptor index for a token, times four bytes per descriptor
  logic [5:0] desc_idx;
  always_comb begin
    desc_idx = 6'h00;
    unique case (pp_mode_ff)
      usb_ep_pkg::PP_ALL: begin
        desc_idx = {token.ep, token.pid == usb_ep_pkg::TOK_IN, token.bank};
      end
      usb_ep_pkg::PP_EP0_OUT: begin
        if (token.ep == 4'h0 && token.pid != usb_ep_pkg::TOK_IN) begin
          desc_idx = {5'h00, token.bank};
        end else begin
          desc_idx = 6'({token.ep, token.pid == usb_ep_pkg::TOK_IN}) + 6'h01;
        end
      end
      default: begin
        desc_idx = {1'b0, token.ep, token.pid == usb_ep_pkg::TOK_IN};
      end
    endcase
  end
  assign token_desc_addr = {2'h0, desc_idx, usb_ep_pkg::DESC_OFS_STATUS};

  // token decision
  logic [4:0] cur_ctrl;
  logic       ep_on;
  logic       dir_ok;

  assign cur_ctrl = ep_ctrl_ff[token.ep];
  assign ep_on    = cur_ctrl[usb_ep_pkg::EPC_IN] || cur_ctrl[usb_ep_pkg::EPC_OUT];

  always_comb begin
    unique case (token.pid)
      usb_ep_pkg::TOK_IN:  dir_ok = cur_ctrl[usb_ep_pkg::EPC_IN];
      usb_ep_pkg::TOK_OUT: dir_ok = cur_ctrl[usb_ep_pkg::EPC_OUT];
      // setup rides on the out path and is refused when control is disabled with IN enabled
      usb_ep_pkg::TOK_SETUP: dir_ok = cur_ctrl[usb_ep_pkg::EPC_OUT] &&
                                      !(cur_ctrl[usb_ep_pkg::EPC_CONDIS] &&
                                        cur_ctrl[usb_ep_pkg::EPC_IN]);
      default: dir_ok = 1'b0;
    endcase
  end

  always_comb begin
    if (!token_valid || !ep_on || !dir_ok) begin
      token_answer = usb_ep_pkg::ANS_IGNORE;
    end else if (cur_ctrl[usb_ep_pkg::EPC_STALL]) begin
      token_answer = usb_ep_pkg::ANS_STALL;
    end else if (status_fifo_full) begin
      token_answer = usb_ep_pkg::ANS_NAK;
    end else begin
      token_answer = usb_ep_pkg::ANS_ACCEPT;
    end
  end
  assign token_handshake = token_valid && cur_ctrl[usb_ep_pkg::EPC_HANDSHAKE];

  // shared ram: cpu port on the bus, engine port direct
  logic       cpu_ram_en;
  logic [7:0] cpu_ram_rdata;
  logic       eng_status_rd_ff;

  assign cpu_ram_en = acc && is_ram && mapped && (pwrite ? pstrb[0] : !rd_wait_ff);

  usb_dual_ram #(
    .DEPTH  (usb_ep_pkg::RAM_BYTES),
    .ADDR_W (usb_ep_pkg::RAM_ADDR_W),
    .WIDTH  (8)
  ) u_ram (
    .clk     (pclk),
    .a_en    (cpu_ram_en),
    .a_we    (pwrite),
    .a_addr  (ram_idx),
    .a_wdata (pwdata[7:0]),
    .a_rdata (cpu_ram_rdata),
    .b_en    (eng_ram_en),
    .b_we    (eng_ram_we),
    .b_addr  (eng_ram_addr),
    .b_wdata (eng_ram_wdata),
    .b_rdata (eng_ram_rdata)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng_status_rd_ff <= 1'b0;
    end else if (eng_ram_en) begin
      eng_status_rd_ff <= !eng_ram_we && (eng_ram_addr[9:8] == 2'h0) &&
                          (eng_ram_addr[1:0] == usb_ep_pkg::DESC_OFS_STATUS);
    end
  end

  // status byte decoded by its owner bit; the cpu view is valid only when not owned
  always_comb begin
    eng_desc_view           = '0;
    eng_desc_view.own       = eng_status_rd_ff && eng_ram_rdata[usb_ep_pkg::DS_OWN];
    eng_desc_view.cpu_view  = eng_status_rd_ff && !eng_ram_rdata[usb_ep_pkg::DS_OWN];
    eng_desc_view.toggle    = eng_ram_rdata[usb_ep_pkg::DS_TOGGLE];
    eng_desc_view.count_hi  = eng_ram_rdata[1:0];
    if (eng_desc_view.cpu_view) begin
      eng_desc_view.keep      = eng_ram_rdata[usb_ep_pkg::DS_KEEP];
      eng_desc_view.incdis    = eng_ram_rdata[usb_ep_pkg::DS_INCDIS];
      eng_desc_view.toggle_en = eng_ram_rdata[usb_ep_pkg::DS_TOGGLE_EN];
      eng_desc_view.buf_stall = eng_ram_rdata[usb_ep_pkg::DS_BUF_STALL];
    end else if (eng_desc_view.own) begin
      eng_desc_view.pid = eng_ram_rdata[usb_ep_pkg::DS_PID_LSB +: 4];
    end
  end

  // read data
  logic [31:0] rd_ff;
  logic        rd_ram_ff;
  logic [31:0] nxt_rd;
  usb_ep_pkg::xfer_info_t head;

  assign head = fifo_ff[rd_ptr_ff];

  always_comb begin
    nxt_rd = 32'h0000_0000;
    if (is_ep) begin
      nxt_rd = {27'h0, ep_ctrl_ff[ep_sel]};
    end else begin
      unique case (paddr)
        usb_ep_pkg::OFS_XFER_STATUS: begin
          nxt_rd[usb_ep_pkg::XS_EP_LSB +: 4] = head.ep;
          nxt_rd[usb_ep_pkg::XS_DIR]         = head.dir;
          nxt_rd[usb_ep_pkg::XS_BANK]        = head.bank;
        end
        usb_ep_pkg::OFS_XFER_FLAG:  nxt_rd = {30'h0, bus_reset_flag_ff, xfer_flag};
        usb_ep_pkg::OFS_DEV_ADDR:   nxt_rd = {25'h0, dev_addr_ff};
        usb_ep_pkg::OFS_FRAME_LOW:  nxt_rd = {24'h0, frame_ff[7:0]};
        usb_ep_pkg::OFS_FRAME_HIGH: nxt_rd = {29'h0, frame_ff[10:8]};
        usb_ep_pkg::OFS_USB_CFG:    nxt_rd = {30'h0, pp_mode_ff};
        usb_ep_pkg::OFS_TABLE_SIZE: nxt_rd = {23'h0, table_bytes};
        default:                    nxt_rd = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ff     <= 32'h0000_0000;
      rd_ram_ff <= 1'b0;
    end else if (acc && !pwrite && !rd_wait_ff) begin
      rd_ff     <= nxt_rd;
      rd_ram_ff <= is_ram;
    end
  end

  assign prdata = rd_ram_ff ? {24'h0, cpu_ram_rdata} : rd_ff;

endmodule

// ==== logic/usb_ep_pkg.sv ====
package usb_ep_pkg;

  localparam int NUM_EP      = 16;
  localparam int PADDR_W     = 13;
  localparam int RAM_BYTES   = 1024;
  localparam int RAM_ADDR_W  = 10;
  localparam int FIFO_DEPTH  = 4;

  // register word offsets on the bus
  localparam logic [12:0] OFS_XFER_STATUS = 13'h0000;
  localparam logic [12:0] OFS_XFER_FLAG   = 13'h0004;
  localparam logic [12:0] OFS_DEV_ADDR    = 13'h0008;
  localparam logic [12:0] OFS_FRAME_LOW   = 13'h000C;
  localparam logic [12:0] OFS_FRAME_HIGH  = 13'h0010;
  localparam logic [12:0] OFS_USB_CFG     = 13'h0014;
  localparam logic [12:0] OFS_TABLE_SIZE  = 13'h0018;
  localparam logic [12:0] OFS_EP_CTRL     = 13'h0040;
  localparam logic [12:0] OFS_EP_CTRL_END = 13'h007C;
  // one bus word per ram byte, ram byte k at RAM_WIN_BASE + 4*k
  localparam logic [12:0] RAM_WIN_BASE    = 13'h1000;

  // data memory map of the shared ram
  localparam logic [11:0] RAM_MAP_BASE    = 12'h400;
  localparam logic [11:0] RAM_MAP_TOP     = 12'h7FF;
  localparam logic [11:0] TABLE_MAP_TOP   = 12'h4FF;
  localparam int          TABLE_MIN_BYTES = 8;
  localparam int          TABLE_MAX_BYTES = 256;

  // descriptor layout: four bytes per descriptor
  localparam int          DESC_BYTES      = 4;
  localparam logic [1:0]  DESC_OFS_STATUS = 2'h0;
  localparam logic [1:0]  DESC_OFS_COUNT  = 2'h1;
  localparam logic [1:0]  DESC_OFS_ADDR_L = 2'h2;
  localparam logic [1:0]  DESC_OFS_ADDR_H = 2'h3;

  // status byte bits; own, toggle and count bits 1..0 are shared by both views
  localparam int DS_OWN       = 7;
  localparam int DS_TOGGLE    = 6;
  localparam int DS_KEEP      = 5;
  localparam int DS_INCDIS    = 4;
  localparam int DS_TOGGLE_EN = 3;
  localparam int DS_BUF_STALL = 2;
  localparam int DS_PID_LSB   = 2;

  // endpoint control bits
  localparam int EPC_HANDSHAKE = 4;
  localparam int EPC_CONDIS    = 3;
  localparam int EPC_OUT       = 2;
  localparam int EPC_IN        = 1;
  localparam int EPC_STALL     = 0;
  localparam logic [4:0] EPC_RST = 5'h00;

  // transfer status bits
  localparam int XS_EP_LSB = 3;
  localparam int XS_DIR    = 2;
  localparam int XS_BANK   = 1;

  localparam logic [6:0] DEV_ADDR_RST  = 7'h00;
  localparam logic [1:0] PP_MODE_RST   = 2'h0;
  localparam logic [1:0] PP_NONE       = 2'h0;
  localparam logic [1:0] PP_EP0_OUT    = 2'h1;
  localparam logic [1:0] PP_ALL        = 2'h2;

  typedef enum logic [1:0] {TOK_OUT, TOK_IN, TOK_SETUP} token_pid_t;
  typedef enum logic [1:0] {ANS_ACCEPT, ANS_NAK, ANS_STALL, ANS_IGNORE} answer_t;

  typedef struct packed {
    logic [3:0] ep;
    logic       dir;
    logic       bank;
  } xfer_info_t;

  typedef struct packed {
    logic [3:0] ep;
    token_pid_t pid;
    logic       bank;
  } token_t;

  typedef struct packed {
    logic       own;
    logic       cpu_view;
    logic       toggle;
    logic       keep;
    logic       incdis;
    logic       toggle_en;
    logic       buf_stall;
    logic [3:0] pid;
    logic [1:0] count_hi;
  } desc_view_t;

endpackage

// ==== logic/usb_dual_ram.sv ====
`timescale 1ns/10ps
// shared byte ram; the engine port wins a same-address write collision
module usb_dual_ram #(
  parameter int DEPTH  = 1024,
  parameter int ADDR_W = 10,
  parameter int WIDTH  = 8
) (
  input  wire logic              clk,
  input  wire logic              a_en,
  input  wire logic              a_we,
  input  wire logic [ADDR_W-1:0] a_addr,
  input  wire logic [WIDTH-1:0]  a_wdata,
  output logic      [WIDTH-1:0]  a_rdata,
  input  wire logic              b_en,
  input  wire logic              b_we,
  input  wire logic [ADDR_W-1:0] b_addr,
  input  wire logic [WIDTH-1:0]  b_wdata,
  output logic      [WIDTH-1:0]  b_rdata
);

  // no reset: contents are undefined after any reset
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (b_en && b_we) begin
      mem[b_addr] <= b_wdata;
    end
    if (a_en && a_we && !(b_en && b_we && (b_addr == a_addr))) begin
      mem[a_addr] <= a_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (a_en) begin
      a_rdata <= mem[a_addr];
    end
  end

  always_ff @(posedge clk) begin
    if (b_en) begin
      b_rdata <= mem[b_addr];
    end
  end

endmodule

// ==== tb/usb_ep_checker.sv ====
`timescale 1ns/10ps
module usb_ep_checker (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic                pready,
  input wire logic                xfer_done,
  input wire logic                token_valid,
  input wire usb_ep_pkg::answer_t token_answer,
  input wire logic                token_handshake,
  input wire logic                bus_reset,
  input wire logic [6:0]          device_address,
  input wire logic                status_fifo_full,
  input wire logic                xfer_flag
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence rd_setup;
    psel && !penable && !pwrite;
  endsequence
  sequence rd_answer;
    !pready ##1 pready;
  endsequence
  a_read_wait: assert property (rd_setup ##1 penable |-> rd_answer)
    else $error("read not answered after one wait");
  a_write_ready: assert property (psel && penable && pwrite |-> pready)
    else $error("write access not ready");
  a_idle_ignore: assert property (
    !token_valid |-> token_answer == usb_ep_pkg::ANS_IGNORE)
    else $error("answer without a token");
  a_hs_valid: assert property (token_handshake |-> token_valid)
    else $error("handshake without a token");
  a_full_nak: assert property (
    token_valid && status_fifo_full |-> token_answer != usb_ep_pkg::ANS_ACCEPT)
    else $error("accepted while fifo full");
  a_addr_clear: assert property (bus_reset |=> device_address == 7'h00)
    else $error("address kept over bus reset");
  a_addr_hold: assert property (!bus_reset && !(psel && pwrite) |=> $stable(device_address))
    else $error("address moved on its own");
  a_push_flag: assert property (xfer_done |=> xfer_flag)
    else $error("no flag after transfer");
  a_full_keep: assert property (status_fifo_full && !(psel && pwrite) |=> status_fifo_full)
    else $error("fifo drained without a pop");
endmodule

bind usb_endpoint_status_bdt usb_ep_checker i_usb_ep_checker (.*);

// ==== tb/usb_engine_model.sv ====
`timescale 1ns/10ps
module usb_engine_model (
  input  wire logic              pclk,
  output logic                   xfer_done,
  output usb_ep_pkg::xfer_info_t xfer_info,
  output logic                   token_valid,
  output usb_ep_pkg::token_t     token,
  output logic                   stall_issued,
  output logic [3:0]             stall_ep,
  output logic                   sof_valid,
  output logic [10:0]            sof_frame,
  output logic                   bus_reset,
  output logic                   eng_ram_en,
  output logic                   eng_ram_we,
  output logic [9:0]             eng_ram_addr,
  output logic [7:0]             eng_ram_wdata,
  input  wire logic [7:0]        eng_ram_rdata
);
  initial begin
    {xfer_done, token_valid, stall_issued, sof_valid, bus_reset} = 5'h00;
    {eng_ram_en, eng_ram_we} = 2'h0;
    xfer_info = 6'h00;
    token = 7'h00;
    stall_ep = 4'h0;
    sof_frame = 11'h000;
    eng_ram_addr = 10'h000;
    eng_ram_wdata = 8'h00;
  end
  // data values are inverted on release so a stale value never looks valid
  task automatic done(input usb_ep_pkg::xfer_info_t i);
    xfer_done <= 1'b1;
    xfer_info <= i;
    @(posedge pclk);
    xfer_done <= 1'b0;
    xfer_info <= ~i;
    @(posedge pclk);
  endtask
  task automatic tok(input logic [3:0] ep, input usb_ep_pkg::token_pid_t p);
    token_valid <= 1'b1;
    token <= '{ep, p, 1'b0};
    @(posedge pclk);
  endtask
  task automatic tok_off();
    @(posedge pclk);
    token_valid <= 1'b0;
    token.ep <= ~token.ep;
    @(posedge pclk);
  endtask
  task automatic stall(input logic [3:0] ep);
    stall_issued <= 1'b1;
    stall_ep <= ep;
    @(posedge pclk);
    stall_issued <= 1'b0;
    stall_ep <= ~ep;
    @(posedge pclk);
  endtask
  task automatic sof(input logic [10:0] f);
    sof_valid <= 1'b1;
    sof_frame <= f;
    @(posedge pclk);
    sof_valid <= 1'b0;
    sof_frame <= ~f;
    @(posedge pclk);
  endtask
  task automatic breset();
    bus_reset <= 1'b1;
    @(posedge pclk);
    bus_reset <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic ram(input logic w, input logic [9:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    eng_ram_en <= 1'b1;
    eng_ram_we <= w;
    eng_ram_addr <= a;
    eng_ram_wdata <= d;
    @(posedge pclk);
    {eng_ram_en, eng_ram_we} <= 2'h0;
    eng_ram_addr <= ~a;
    eng_ram_wdata <= ~d;
    #1 q = eng_ram_rdata;
    @(posedge pclk);
  endtask
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  logic                    pclk = 1'b0;
  logic                    presetn = 1'b0;
  logic                    psel = 1'b0;
  logic                    penable = 1'b0;
  logic                    pwrite = 1'b0;
  logic [12:0]             paddr = 13'h0000;
  logic [31:0]             pwdata = 32'h00000000;
  logic [3:0]              pstrb = 4'hF;
  logic [31:0]             prdata, rdat;
  logic                    pready, pslverr, rerr, token_handshake;
  usb_ep_pkg::answer_t     token_answer;
  logic [9:0]              token_desc_addr;
  logic [6:0]              device_address;
  logic [15:0]             desc_live;
  logic [8:0]              table_bytes;
  logic                    status_fifo_full, xfer_flag;
  wire                     xfer_done, token_valid, stall_issued, sof_valid, bus_reset;
  wire                     eng_ram_en, eng_ram_we;
  usb_ep_pkg::xfer_info_t  xfer_info;
  usb_ep_pkg::token_t      token;
  wire [3:0]               stall_ep;
  wire [10:0]              sof_frame;
  wire [9:0]               eng_ram_addr;
  wire [7:0]               eng_ram_wdata, eng_ram_rdata;
  logic [7:0]              q;
  logic [5:0]              ds [5] = '{6'h06, 6'h09, 6'h3F, 6'h1C, 6'h26};
  int                      fails = 0;
  int                      compares = 0;

  always #20 pclk = ~pclk;

  usb_endpoint_status_bdt i_usb_endpoint_status_bdt (.eng_desc_view(), .*);

  usb_engine_model i_usb_engine_model (.*);

  task automatic end_sim();
    if (fails == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_ans(input usb_ep_pkg::answer_t got, input usb_ep_pkg::answer_t exp);
    chk({30'h0, got}, {30'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    {rerr, rdat} = {pslverr, prdata};
    if (pready !== 1'b1) begin
      fails++;
      end_sim();
    end
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask
  task automatic rc(input logic [12:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  function automatic logic [12:0] ep_a(input int n);
    return usb_ep_pkg::OFS_EP_CTRL + 13'(4 * n);
  endfunction
  task automatic tk(input logic [4:0] c, input usb_ep_pkg::token_pid_t p,
                    input usb_ep_pkg::answer_t e, input logic hs);
    apb(1'b1, ep_a(3), {27'h0, c});
    i_usb_engine_model.tok(4'h3, p);
    #1 chk_ans(token_answer, e);
    chk({31'h0, token_handshake}, {31'h0, hs});
    i_usb_engine_model.tok_off();
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int n = 0; n < 16; n++) rc(ep_a(n), 32'h0);
    for (int n = 0; n < 16; n++) apb(1'b1, ep_a(n), {24'hFFFFFF, 3'h7, 5'(n)});
    for (int n = 0; n < 16; n++) begin
      rc(ep_a(n), 32'(n));
      apb(1'b1, ep_a(n), 32'h0);
    end
    tk(5'h00, usb_ep_pkg::TOK_OUT, usb_ep_pkg::ANS_IGNORE, 1'b0);
    tk(5'h04, usb_ep_pkg::TOK_OUT, usb_ep_pkg::ANS_ACCEPT, 1'b0);
    tk(5'h04, usb_ep_pkg::TOK_IN, usb_ep_pkg::ANS_IGNORE, 1'b0);
    tk(5'h02, usb_ep_pkg::TOK_IN, usb_ep_pkg::ANS_ACCEPT, 1'b0);
    tk(5'h06, usb_ep_pkg::TOK_SETUP, usb_ep_pkg::ANS_ACCEPT, 1'b0);
    tk(5'h0E, usb_ep_pkg::TOK_SETUP, usb_ep_pkg::ANS_IGNORE, 1'b0);
    tk(5'h0E, usb_ep_pkg::TOK_IN, usb_ep_pkg::ANS_ACCEPT, 1'b0);
    tk(5'h16, usb_ep_pkg::TOK_OUT, usb_ep_pkg::ANS_ACCEPT, 1'b1);
    tk(5'h01, usb_ep_pkg::TOK_OUT, usb_ep_pkg::ANS_IGNORE, 1'b0);
    tk(5'h06, usb_ep_pkg::TOK_IN, usb_ep_pkg::ANS_ACCEPT, 1'b0);
    chk(desc_live, 16'h0008);
    i_usb_engine_model.tok(4'h3, usb_ep_pkg::TOK_IN);
    #1 chk(token_desc_addr, 10'd28);
    i_usb_engine_model.tok_off();
    i_usb_engine_model.stall(4'h3);
    rc(ep_a(3), 32'h07);
    tk(5'h07, usb_ep_pkg::TOK_OUT, usb_ep_pkg::ANS_STALL, 1'b0);
    foreach (ds[i]) i_usb_engine_model.done(ds[i]);
    chk({31'h0, status_fifo_full}, 32'h1);
    tk(5'h06, usb_ep_pkg::TOK_OUT, usb_ep_pkg::ANS_NAK, 1'b0);
    for (int i = 0; i < 4; i++) begin
      rc(usb_ep_pkg::OFS_XFER_FLAG, 32'h1);
      rc(usb_ep_pkg::OFS_XFER_STATUS, {25'h0, ds[i], 1'b0});
      apb(1'b1, usb_ep_pkg::OFS_XFER_FLAG, 32'h1);
    end
    rc(usb_ep_pkg::OFS_XFER_FLAG, 32'h0);
    apb(1'b1, usb_ep_pkg::OFS_DEV_ADDR, 32'h2A);
    rc(usb_ep_pkg::OFS_DEV_ADDR, 32'h2A);
    i_usb_engine_model.breset();
    rc(usb_ep_pkg::OFS_DEV_ADDR, 32'h0);
    rc(usb_ep_pkg::OFS_XFER_FLAG, 32'h2);
    chk({14'h0, device_address, table_bytes, status_fifo_full, xfer_flag}, 32'h200);
    i_usb_engine_model.sof(11'h5A3);
    apb(1'b1, usb_ep_pkg::OFS_FRAME_LOW, 32'h11);
    rc(usb_ep_pkg::OFS_FRAME_LOW, 32'hA3);
    rc(usb_ep_pkg::OFS_FRAME_HIGH, 32'h5);
    apb(1'b1, 13'h1404, 32'h5C);
    i_usb_engine_model.ram(1'b0, 10'h101, 8'h00, q);
    chk(q, 8'h5C);
    i_usb_engine_model.ram(1'b1, 10'h3FF, 8'hC3, q);
    rc(13'h1FFC, 32'hC3);
    rc(13'h0020, 32'h0);
    chk(rerr, 1'b1);
    rc(usb_ep_pkg::OFS_TABLE_SIZE, 32'h80);
    apb(1'b1, usb_ep_pkg::OFS_USB_CFG, 32'h1);
    rc(usb_ep_pkg::OFS_TABLE_SIZE, 32'h84);
    apb(1'b1, usb_ep_pkg::OFS_USB_CFG, 32'h2);
    rc(usb_ep_pkg::OFS_TABLE_SIZE, 32'h100);
    end_sim();
  end
endmodule
